// [logic/stop_esc_regs.svh]
`ifndef STOP_ESC_REGS_SVH
`define STOP_ESC_REGS_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STOP_REQ 8'h04
`define OFS_STATUS 8'h08
`define OFS_MSG_VALUE 8'h0c
`define OFS_DIAG 8'h10
`define OFS_TEST_STOP_TIMEOUT 8'h14
`define OFS_RAMP_TO_CANCEL 8'h18
`define OFS_CANCEL_SPEED 8'h1c
`define OFS_CONTROLLED_T 8'h20
`define OFS_PATH_T 8'h24
`define OFS_RETRACT_T 8'h28
`define OFS_FAULT_T 8'h2c
`define OFS_FORCED_CHECK 8'h30
`define OFS_RESPONSE 8'h34
`define OFS_ACCEL_TOL 8'h38
`define OFS_STOP_TOL 8'h3c
`define OFS_BRAKE_NORM 8'h40
`define OFS_CHANGEOVER_TOL 8'h44
`define OFS_LIMIT_BASE 8'h60

// control word fields
`define CTRL_TEST_STOP 0
`define CTRL_SAFE_STANDSTILL 1
`define CTRL_COMM_OK 2
`define CTRL_COMMISSION 3
`define CTRL_ACCEPT 4
`define CTRL_MON_ACTIVE 5
`define CTRL_REFERENCED 6
`define CTRL_USER_AGREE 7
`define CTRL_SE1_EN 8
`define CTRL_SE2_EN 9
`define CTRL_LIMIT_LO 10
`define CTRL_AXIS_TYPE 12
`define CTRL_ACK 15
`define CTRL_RESET 16'h0000

// stop request word bits
`define REQ_CANCEL 0
`define REQ_RAMP 1
`define REQ_CONTROLLED 2
`define REQ_PATH 3
`define REQ_RETRACT 4

// reset values of the time and tolerance settings
`define TIME_RESET 32'h0000_0064
`define SPEED_THR_RESET 16'h0010
`define TOL_RESET 32'h0000_0100

// message codes
`define CODE_SPEED_STEP 16'h0064
`define CODE_ENC_FREQ 16'h03e8
`define CODE_SE1_LO 16'h000a
`define CODE_SE2_LO 16'h0014
`define CODE_RECONFIG 16'h006c
`define CODE_BRAKE_NORM 16'h07d3
`define CODE_NOT_REFERENCED 16'h0001
`define CODE_NO_AGREEMENT 16'h0002
`define CODE_SWITCH_WD 10'h3e8

// timing: settings count in units of one microsecond
`define CLK_PERIOD_NS 4
`define TIME_UNIT_NS 1000
`define TICKS_PER_UNIT (`TIME_UNIT_NS / `CLK_PERIOD_NS)
`define SWITCH_WINDOW_MULT 5
`define SWITCH_LIMIT 8

`endif

// [logic/stop_esc_pkg.sv]
package stop_esc_pkg;

	// ordered by severity, lowest first
	typedef enum logic [2:0] {
		ST_RUN,
		ST_SOS,
		ST_FAULT,
		ST_RETRACT,
		ST_PATH,
		ST_CONTROLLED,
		ST_RAMP,
		ST_CANCEL
	} stop_state_t;

	typedef struct packed {
		logic [15:0] speed;
		logic [31:0] pos;
		logic [31:0] setpoint;
		logic [31:0] saved_pos;
		logic pulses_off;
		logic xcmp_mismatch;
		logic [9:0] xcmp_item;
		logic sge_toggle;
		logic enc_over;
	} drive_fb_t;

	typedef struct packed {
		logic pulse_enable;
		logic fast_ramp;
		logic path_brake;
		logic retract;
		logic hold_position;
	} drive_cmd_t;

endpackage : stop_esc_pkg

// [logic/countdown_timer.sv]
`timescale 1ns/1ps
// counts value time units after load; expired is a level until the next load
module countdown_timer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic load,
	input wire logic tick,
	input wire logic [31:0] value,
	output logic expired
);
	logic [31:0] cnt_q;
	logic run_q;

	// load wins over counting so a restart is never lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 32'h0000_0000;
			run_q <= 1'b0;
			expired <= 1'b0;
		end else if (load) begin
			cnt_q <= value;
			run_q <= (value != 32'h0000_0000);
			expired <= (value == 32'h0000_0000);
		end else if (run_q && tick) begin
			if (cnt_q <= 32'h0000_0001) begin
				run_q <= 1'b0;
				expired <= 1'b1;
			end
			cnt_q <= cnt_q - 32'h0000_0001;
		end
	end
endmodule : countdown_timer

// [logic/limit_table_mem.sv]
`timescale 1ns/1ps
// eight limit words: four speed limits, then lower/upper end positions of two sets
module limit_table_mem (
	input wire logic hclk,
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [31:0] wdata,
	input wire logic [2:0] raddr,
	output logic [31:0] rdata_q
);
	logic [31:0] mem [8];

	// no reset: software must load the table before enabling monitoring
	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule : limit_table_mem

// [logic/safe_motion_stop_escalation.sv]
`timescale 1ns/1ps
`include "stop_esc_regs.svh"
// How it works
// RULE_01 - immediate cancel stop removes pulses; reset command acknowledges it
// RULE_02 - test stop not cancelling pulses before its timeout raises immediate cancel
// RULE_03 - ramp stop escalates to cancel on its timer or low speed
// RULE_04 - speed above acceleration tolerance in ramp stops raises alarm and cancel
// RULE_05 - position deviation beyond tolerance in safe operating stop starts ramp stop
// RULE_06 - controlled ramp stop enters safe operating stop on its timer
// RULE_07 - path stop enters safe operating stop on its timer
// RULE_08 - retraction stop enters safe operating stop on its timer
// RULE_09 - comparison mismatch enters fault stop, then ramp stop if monitoring
// RULE_10 - item number causing fault stop is kept readable
// RULE_11 - speed over active limit reports 100..400 or 1000 and stops
// RULE_12 - end position passed reports 10, 11, 20 or 21
// RULE_13 - speed and end alarms trigger the configured braking stop
// RULE_14 - forced check interval expiry flags test; standstill release clears and restarts
// RULE_15 - without controller link pulses stay cancelled and a wait flag shows
// RULE_16 - power-up position mismatch reports 1 unreferenced or 2 no agreement; the code checks only in the first cycle after reset and so never reports 2
// RULE_17 - test-stop-running flag holds while the test stop is active
// RULE_18 - acceptance mode lets reset clear power-on class alarms
// RULE_19 - commissioning flag shows while selected, without any stop
// RULE_20 - axis type change corrects config bit, reports 108, ramp stop
// RULE_21 - brake torque scaling change flags brake acceptance repeat
// RULE_22 - most severe pending stop wins, cancel above all braking
// RULE_23 - too many input switches in five tolerance times gives code 1000
module safe_motion_stop_escalation
	import stop_esc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata_q,
	output logic hreadyout_q,
	output logic hresp_q,
	input wire drive_fb_t drive_fb,
	output drive_cmd_t drive_cmd_q
);
	// bus data phase tracking
	logic dph_valid_q;
	logic dph_write_q;
	logic [7:0] dph_addr_q;
	logic wr_en;
	logic [31:0] rd_mux;

	// software settings
	logic [15:0] ctrl_q;
	logic [31:0] test_stop_timeout_q, ramp_to_cancel_time_q, controlled_stop_transition_time_q;
	logic [31:0] path_stop_transition_time_q, retract_stop_transition_time_q;
	logic [31:0] fault_to_ramp_transition_time_q, forced_check_interval_q;
	logic [31:0] accel_tol_q, stop_tol_q, changeover_tol_q;
	logic [15:0] cancel_speed_threshold_q;
	logic [3:0] speed_limit_stop_response_q;
	logic [4:0] sw_req_q;
	logic ack_q, brake_norm_wr_q;

	// stop sequencing and monitor state
	stop_state_t state_q, state_d;
	logic [31:0] tmr_val [3];
	logic [2:0] tmr_load, tmr_exp;
	logic [7:0] prescale_q;
	logic tick_q;
	logic [2:0] scan_q, scan_d1_q;
	logic [31:0] lim_rdata;
	logic [15:0] min_speed_q, message_value_q;
	logic [9:0] fault_stop_diag_value_q;
	logic [7:0] alarm_q, alarm_set, alarm_clr;
	logic test_sel_q, sh_sel_q, ts_active_q, init_load_q, axis_cfg_q, pu_done_q;
	logic [31:0] win_q;
	logic [3:0] switch_cnt_q;
	logic spd_ev, end_ev, accel_viol, sos_viol, test_fail, wd_trip, reconfig_ev, ack_ok;
	logic [15:0] spd_code, end_code;
	logic [3:0] brake_trig;
	logic signed [32:0] pdiff, pabs;

	// ahb-lite slave: writes take no wait state, reads take one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_valid_q <= 1'b0;
			dph_write_q <= 1'b0;
			dph_addr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			if (hready) begin
				dph_valid_q <= hsel && htrans[1];
				dph_write_q <= hwrite;
				dph_addr_q <= haddr[7:0];
			end
			hreadyout_q <= !(hready && hsel && htrans[1] && !hwrite);
		end
	end

	assign wr_en = dph_valid_q && dph_write_q && hreadyout_q;

	// register read decode, unmapped and table words read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (dph_addr_q)
			`OFS_CTRL: rd_mux = {16'h0000, ctrl_q};
			`OFS_STATUS: rd_mux = {16'h0000, axis_cfg_q, tmr_exp[2], ts_active_q,
				!ctrl_q[`CTRL_COMM_OK], alarm_q, state_q, 1'b0};
			`OFS_MSG_VALUE: rd_mux = {16'h0000, message_value_q};
			`OFS_DIAG: rd_mux = {22'h000000, fault_stop_diag_value_q};
			`OFS_TEST_STOP_TIMEOUT: rd_mux = test_stop_timeout_q;
			`OFS_RAMP_TO_CANCEL: rd_mux = ramp_to_cancel_time_q;
			`OFS_CANCEL_SPEED: rd_mux = {16'h0000, cancel_speed_threshold_q};
			`OFS_CONTROLLED_T: rd_mux = controlled_stop_transition_time_q;
			`OFS_PATH_T: rd_mux = path_stop_transition_time_q;
			`OFS_RETRACT_T: rd_mux = retract_stop_transition_time_q;
			`OFS_FAULT_T: rd_mux = fault_to_ramp_transition_time_q;
			`OFS_FORCED_CHECK: rd_mux = forced_check_interval_q;
			`OFS_RESPONSE: rd_mux = {28'h0000000, speed_limit_stop_response_q};
			`OFS_ACCEL_TOL: rd_mux = accel_tol_q;
			`OFS_STOP_TOL: rd_mux = stop_tol_q;
			`OFS_CHANGEOVER_TOL: rd_mux = changeover_tol_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data is loaded in the wait cycle so a preceding write is visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (dph_valid_q && !dph_write_q && !hreadyout_q) begin
			hrdata_q <= rd_mux;
		end
	end

	// register writes; request, acknowledge and brake scaling writes are pulses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `CTRL_RESET;
			test_stop_timeout_q <= `TIME_RESET;
			ramp_to_cancel_time_q <= `TIME_RESET;
			cancel_speed_threshold_q <= `SPEED_THR_RESET;
			controlled_stop_transition_time_q <= `TIME_RESET;
			path_stop_transition_time_q <= `TIME_RESET;
			retract_stop_transition_time_q <= `TIME_RESET;
			fault_to_ramp_transition_time_q <= `TIME_RESET;
			forced_check_interval_q <= `TIME_RESET;
			speed_limit_stop_response_q <= 4'h0;
			accel_tol_q <= `TOL_RESET;
			stop_tol_q <= `TOL_RESET;
			changeover_tol_q <= `TIME_RESET;
			sw_req_q <= 5'h00;
			ack_q <= 1'b0;
			brake_norm_wr_q <= 1'b0;
		end else begin
			sw_req_q <= 5'h00;
			ack_q <= 1'b0;
			brake_norm_wr_q <= 1'b0;
			if (wr_en) begin
				unique case (dph_addr_q)
					`OFS_CTRL: begin
						ctrl_q <= {1'b0, hwdata[14:0]};
						ack_q <= hwdata[`CTRL_ACK];
					end
					`OFS_STOP_REQ: sw_req_q <= hwdata[4:0];
					`OFS_TEST_STOP_TIMEOUT: test_stop_timeout_q <= hwdata;
					`OFS_RAMP_TO_CANCEL: ramp_to_cancel_time_q <= hwdata;
					`OFS_CANCEL_SPEED: cancel_speed_threshold_q <= hwdata[15:0];
					`OFS_CONTROLLED_T: controlled_stop_transition_time_q <= hwdata;
					`OFS_PATH_T: path_stop_transition_time_q <= hwdata;
					`OFS_RETRACT_T: retract_stop_transition_time_q <= hwdata;
					`OFS_FAULT_T: fault_to_ramp_transition_time_q <= hwdata;
					`OFS_FORCED_CHECK: forced_check_interval_q <= hwdata;
					`OFS_RESPONSE: speed_limit_stop_response_q <= hwdata[3:0];
					`OFS_ACCEL_TOL: accel_tol_q <= hwdata;
					`OFS_STOP_TOL: stop_tol_q <= hwdata;
					// RULE_21 scaling change noted
					`OFS_BRAKE_NORM: brake_norm_wr_q <= 1'b1;
					`OFS_CHANGEOVER_TOL: changeover_tol_q <= hwdata;
					default: ;
				endcase
			end
		end
	end

	// limit table, scanned one word per cycle by the monitors
	limit_table_mem u_limits (
		.hclk(hclk),
		.we(wr_en && (dph_addr_q[7:5] == `OFS_LIMIT_BASE >> 5)),
		.waddr(dph_addr_q[4:2]),
		.wdata(hwdata),
		.raddr(scan_q),
		.rdata_q(lim_rdata)
	);

	// unit tick prescaler
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (prescale_q == 8'(`TICKS_PER_UNIT - 1));
			prescale_q <= (prescale_q == 8'(`TICKS_PER_UNIT - 1)) ? 8'h00 : prescale_q + 8'h01;
		end
	end

	// timer 0 follows the stop state, 1 the test stop, 2 the forced check
	always_comb begin
		tmr_load[0] = (state_d != state_q);
		unique case (state_d)
			ST_RAMP: tmr_val[0] = ramp_to_cancel_time_q;
			ST_CONTROLLED: tmr_val[0] = controlled_stop_transition_time_q;
			ST_PATH: tmr_val[0] = path_stop_transition_time_q;
			ST_RETRACT: tmr_val[0] = retract_stop_transition_time_q;
			ST_FAULT: tmr_val[0] = fault_to_ramp_transition_time_q;
			default: tmr_val[0] = 32'h0000_0000;
		endcase
		tmr_load[1] = ctrl_q[`CTRL_TEST_STOP] && !test_sel_q;
		tmr_val[1] = test_stop_timeout_q;
		// RULE_14 restart on release
		tmr_load[2] = init_load_q || (sh_sel_q && !ctrl_q[`CTRL_SAFE_STANDSTILL]);
		tmr_val[2] = forced_check_interval_q;
	end

	for (genvar i = 0; i < 3; i++) begin : g_tmr
		countdown_timer u_tmr (
			.hclk(hclk),
			.hresetn(hresetn),
			.load(tmr_load[i]),
			.tick(tick_q),
			.value(tmr_val[i]),
			.expired(tmr_exp[i])
		);
	end

	// scan pointer; read data lags the address by one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scan_q <= 3'h0;
			scan_d1_q <= 3'h0;
		end else begin
			scan_q <= scan_q + 3'h1;
			scan_d1_q <= scan_q;
		end
	end

	// speed and end position monitors
	always_comb begin
		// RULE_11 limit codes
		spd_ev = drive_fb.enc_over;
		spd_code = `CODE_ENC_FREQ;
		if (!scan_d1_q[2] && scan_d1_q[1:0] == ctrl_q[`CTRL_LIMIT_LO +: 2]
			&& drive_fb.speed > lim_rdata[15:0]) begin
			spd_ev = 1'b1;
			spd_code = 16'({14'h0000, scan_d1_q[1:0]} + 16'h0001) * `CODE_SPEED_STEP;
		end
		// RULE_12 end position codes
		end_code = (scan_d1_q[1] ? `CODE_SE2_LO : `CODE_SE1_LO) + {15'h0000, scan_d1_q[0]};
		end_ev = scan_d1_q[2] && (scan_d1_q[1] ? ctrl_q[`CTRL_SE2_EN] : ctrl_q[`CTRL_SE1_EN])
			&& (scan_d1_q[0] ? ($signed(drive_fb.pos) > $signed(lim_rdata))
			: ($signed(drive_fb.pos) < $signed(lim_rdata)));
		// RULE_13 configured braking
		brake_trig = (spd_ev ? (4'h1 << speed_limit_stop_response_q[1:0]) : 4'h0)
			| (end_ev ? (4'h1 << speed_limit_stop_response_q[3:2]) : 4'h0);
	end

	// RULE_05 deviation during standstill hold
	always_comb begin
		pdiff = $signed({drive_fb.pos[31], drive_fb.pos})
			- $signed({drive_fb.setpoint[31], drive_fb.setpoint});
		pabs = pdiff[32] ? -pdiff : pdiff;
		sos_viol = (state_q == ST_SOS) && (pabs > $signed({1'b0, stop_tol_q}));
	end

	// RULE_04 speed rising above the lowest seen plus tolerance
	assign accel_viol = (state_q == ST_RAMP || state_q == ST_CONTROLLED)
		&& ({16'h0000, drive_fb.speed} > {16'h0000, min_speed_q} + accel_tol_q);
	// RULE_02 pulses still present at timeout
	assign test_fail = ts_active_q && tmr_exp[1] && !drive_fb.pulses_off;
	assign reconfig_ev = pu_done_q && (ctrl_q[`CTRL_AXIS_TYPE] != axis_cfg_q);
	// RULE_18 power-on class alarms need acceptance mode
	assign ack_ok = ack_q && ctrl_q[`CTRL_ACCEPT];

	// RULE_22 most severe request chosen last
	always_comb begin
		state_d = state_q;
		// RULE_06 to safe operating stop
		if (state_q == ST_CONTROLLED && tmr_exp[0]) state_d = ST_SOS;
		// RULE_07 to safe operating stop
		if (state_q == ST_PATH && tmr_exp[0]) state_d = ST_SOS;
		// RULE_08 to safe operating stop
		if (state_q == ST_RETRACT && tmr_exp[0]) state_d = ST_SOS;
		// RULE_01 reset command acknowledges
		if (ack_q) state_d = ST_RUN;
		// RULE_09 fault stop entry
		if ((drive_fb.xcmp_mismatch || wd_trip) && state_d < ST_FAULT) state_d = ST_FAULT;
		if ((sw_req_q[`REQ_RETRACT] || brake_trig[3]) && state_d < ST_RETRACT) state_d = ST_RETRACT;
		if ((sw_req_q[`REQ_PATH] || brake_trig[2]) && state_d < ST_PATH) state_d = ST_PATH;
		if ((sw_req_q[`REQ_CONTROLLED] || brake_trig[1]) && state_d < ST_CONTROLLED)
			state_d = ST_CONTROLLED;
		// RULE_09 fault escalates when monitoring
		if ((sw_req_q[`REQ_RAMP] || brake_trig[0] || sos_viol || reconfig_ev
			|| (state_q == ST_FAULT && tmr_exp[0] && ctrl_q[`CTRL_MON_ACTIVE]))
			&& state_d < ST_RAMP) state_d = ST_RAMP;
		// RULE_03 time or speed, whichever first
		if (sw_req_q[`REQ_CANCEL] || test_fail || accel_viol || (state_q == ST_RAMP
			&& (tmr_exp[0] || drive_fb.speed < cancel_speed_threshold_q))) state_d = ST_CANCEL;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// lowest speed since entering a ramp stop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			min_speed_q <= 16'h0000;
		end else if (state_d != state_q || drive_fb.speed < min_speed_q) begin
			min_speed_q <= drive_fb.speed;
		end
	end

	// RULE_23 switching watchdog over five changeover times
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_q <= 32'h0000_0000;
			switch_cnt_q <= 4'h0;
			wd_trip <= 1'b0;
		end else begin
			wd_trip <= 1'b0;
			if (tick_q && win_q >= changeover_tol_q * `SWITCH_WINDOW_MULT) begin
				win_q <= 32'h0000_0000;
				switch_cnt_q <= 4'h0;
			end else begin
				win_q <= win_q + {31'h00000000, tick_q};
				if (drive_fb.sge_toggle) begin
					switch_cnt_q <= switch_cnt_q + 4'h1;
					wd_trip <= (switch_cnt_q == 4'(`SWITCH_LIMIT - 1));
				end
			end
		end
	end

	// RULE_10 item number of the fault stop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_stop_diag_value_q <= 10'h000;
		end else if (drive_fb.xcmp_mismatch && state_q != ST_FAULT) begin
			fault_stop_diag_value_q <= drive_fb.xcmp_item;
		end else if (wd_trip && state_q != ST_FAULT) begin
			fault_stop_diag_value_q <= `CODE_SWITCH_WD;
		end
	end

	// sticky alarms: speed, end, accel, standstill, reconfig, brake, reference, fault
	always_comb begin
		alarm_set = {state_d == ST_FAULT && state_q != ST_FAULT, 1'b0, brake_norm_wr_q,
			reconfig_ev, sos_viol, accel_viol, end_ev, spd_ev};
		alarm_clr = {ack_q, ack_ok, ack_q, ack_ok, {4{ack_q}}};
	end

	// set beats a clear arriving in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm_q <= 8'h00;
		end else begin
			alarm_q <= alarm_set | (alarm_q & ~alarm_clr);
			// RULE_16 power-up position check
			if (!pu_done_q && drive_fb.saved_pos != drive_fb.pos
				&& !(ctrl_q[`CTRL_REFERENCED] && ctrl_q[`CTRL_USER_AGREE])) begin
				alarm_q[6] <= 1'b1;
			end
		end
	end

	// coded value of the most recent message
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			message_value_q <= 16'h0000;
		end else if (!pu_done_q && drive_fb.saved_pos != drive_fb.pos) begin
			if (!ctrl_q[`CTRL_REFERENCED]) begin
				message_value_q <= `CODE_NOT_REFERENCED;
			end else if (!ctrl_q[`CTRL_USER_AGREE]) begin
				message_value_q <= `CODE_NO_AGREEMENT;
			end
		end else if (reconfig_ev) begin
			// RULE_20 causing parameter reported
			message_value_q <= `CODE_RECONFIG;
		end else if (spd_ev) begin
			message_value_q <= spd_code;
		end else if (end_ev) begin
			message_value_q <= end_code;
		end else if (brake_norm_wr_q) begin
			message_value_q <= `CODE_BRAKE_NORM;
		end
	end

	// edge history, power-up flag and corrected axis bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_sel_q <= 1'b0;
			sh_sel_q <= 1'b0;
			init_load_q <= 1'b1;
			pu_done_q <= 1'b0;
			axis_cfg_q <= 1'b0;
		end else begin
			test_sel_q <= ctrl_q[`CTRL_TEST_STOP];
			sh_sel_q <= ctrl_q[`CTRL_SAFE_STANDSTILL];
			init_load_q <= 1'b0;
			pu_done_q <= 1'b1;
			// RULE_20 internal bit corrected
			if (!pu_done_q || reconfig_ev) axis_cfg_q <= ctrl_q[`CTRL_AXIS_TYPE];
		end
	end

	// RULE_17 running until pulses seen off or deselected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ts_active_q <= 1'b0;
		end else if (tmr_load[1]) begin
			ts_active_q <= 1'b1;
		end else if (drive_fb.pulses_off || !ctrl_q[`CTRL_TEST_STOP]) begin
			ts_active_q <= 1'b0;
		end
	end

	// RULE_19 commissioning never gates motion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_cmd_q <= '0;
		end else begin
			// RULE_01 RULE_15 pulse removal paths
			drive_cmd_q.pulse_enable <= state_q != ST_CANCEL && ctrl_q[`CTRL_COMM_OK]
				&& !ts_active_q && !ctrl_q[`CTRL_SAFE_STANDSTILL];
			drive_cmd_q.fast_ramp <= state_q == ST_RAMP || state_q == ST_CONTROLLED;
			drive_cmd_q.path_brake <= state_q == ST_PATH;
			drive_cmd_q.retract <= state_q == ST_RETRACT;
			drive_cmd_q.hold_position <= state_q == ST_SOS;
		end
	end
endmodule : safe_motion_stop_escalation

// [bench/stop_esc_sva.sv]
`timescale 1ns/1ps
module stop_esc_sva
	import stop_esc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout_q,
	input wire logic hresp_q,
	input wire drive_cmd_t drive_cmd_q
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wr_q, link_q;
	logic [7:0] adr_q;
	// data phase of a taken write, so hwdata can be judged with its address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			adr_q <= 8'h00;
		end else begin
			wr_q <= hready && hsel && htrans[1] && hwrite;
			adr_q <= haddr[7:0];
		end
	end
	// shadow of the link bit; follows the control word writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			link_q <= 1'b0;
		else if (wr_q && adr_q == 8'h00)
			link_q <= hwdata[2];
	end
	wire req = wr_q && adr_q == 8'h04;
	wire run = drive_cmd_q == 5'h10;
	a_resp_okay: assert property (!hresp_q) else $error("response not okay");
	a_read_wait: assert property (hready && hsel && htrans[1] && !hwrite |=>
		!hreadyout_q ##1 hreadyout_q) else $error("read wait state wrong");
	a_write_nowait: assert property (hready && hsel && htrans[1] && hwrite |=> hreadyout_q)
		else $error("write stalled");
	a_cancel_pulses: assert property (req && hwdata[0] |->
		##[1:4] !drive_cmd_q.pulse_enable [*3]) else $error("pulses not removed");
	a_link_hold: assert property (!link_q && !$past(link_q, 3) |->
		!drive_cmd_q.pulse_enable) else $error("pulses on without link");
	a_ramp_select: assert property (req && hwdata[4:0] == 5'h02 && run |->
		##[1:4] drive_cmd_q.fast_ramp) else $error("ramp stop not applied");
	a_path_select: assert property (req && hwdata[4:0] == 5'h08 && run |->
		##[1:4] drive_cmd_q.path_brake) else $error("path stop not applied");
	a_retract_select: assert property (req && hwdata[4:0] == 5'h10 && run |->
		##[1:4] drive_cmd_q.retract) else $error("retraction not applied");
	cover property (req && hwdata[1]);
	cover property (!drive_cmd_q.pulse_enable ##1 drive_cmd_q.pulse_enable);
	cover property (drive_cmd_q.hold_position);
endmodule : stop_esc_sva

bind safe_motion_stop_escalation stop_esc_sva i_stop_esc_sva (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .drive_cmd_q(drive_cmd_q));

// [bench/drive_sim.sv]
`timescale 1ns/1ps
module drive_sim
	import stop_esc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire drive_cmd_t cmd,
	input wire drive_fb_t ext,
	input wire logic stuck,
	output drive_fb_t fb
);
	logic off_q;
	logic [15:0] spd_q;
	// pulses follow command
	// stuck models a shutdown path that fails to remove pulses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			off_q <= 1'b1;
		else if (!stuck)
			off_q <= !cmd.pulse_enable;
	end
	// braking sheds one step a cycle, else the axis tracks the external speed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			spd_q <= 16'h0000;
		else if (off_q || cmd.fast_ramp || cmd.path_brake || cmd.retract)
			spd_q <= spd_q - 16'(spd_q != 16'h0000);
		else
			spd_q <= ext.speed;
	end
	always_comb begin
		fb = ext;
		fb.speed = spd_q;
		fb.pulses_off = off_q;
	end
endmodule : drive_sim

// [bench/tb_safe_motion_stop_escalation.sv]
`timescale 1ns/1ps
module tb_safe_motion_stop_escalation
	import stop_esc_pkg::*;
();
	logic hclk, hresetn, hsel, hwrite, hready, hresp_q, stuck;
	logic [31:0] haddr, hwdata, hrdata_q, rv, ctl;
	logic [1:0] htrans;
	drive_fb_t ext, fb;
	drive_cmd_t cmd;
	int n_fail, compares, cyc;
	safe_motion_stop_escalation i_safe_motion_stop_escalation (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata_q(hrdata_q),
		.hreadyout_q(hready), .hresp_q(hresp_q), .drive_fb(fb), .drive_cmd_q(cmd));
	drive_sim i_drive_sim (.hclk(hclk), .hresetn(hresetn), .cmd(cmd), .ext(ext),
		.stuck(stuck), .fb(fb));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// one single word transfer; the slave sets the pace
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d = 0);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rv = hrdata_q;
	endtask : bus
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic sts(input logic [2:0] e);
		bus(0, 8'h08);
		chk(rv[3:1], e, "state");
	endtask : sts
	task automatic set(input logic [31:0] v);
		ctl = v;
		bus(1, 8'h00, v);
	endtask : set
	task automatic ack();
		bus(1, 8'h00, ctl | 32'h8000);
	endtask : ack
	// short transition times so each stop settles in a few hundred cycles
	task automatic t_cfg();
		for (int a = 20; a <= 44; a += 4)
			if (a != 28)
				bus(1, 8'(a), 32'h2);
		for (int i = 0; i < 8; i++)
			bus(1, 8'(96 + 4 * i), i < 4 ? (i == 2 ? 50 : 200) : (i % 2 ? 1000 : -1000));
	endtask : t_cfg
	task automatic t_power_up();
		chk(cmd.pulse_enable, 1'b0, "pulse_enable");
		bus(0, 8'h08);
		chk(rv[12], 1'b1, "wait_link");
		chk(rv[10], 1'b1, "not_referenced");
		bus(0, 8'h0c);
		chk(rv, 32'h1, "msg_value");
		set(32'h14);
		ack();
		bus(0, 8'h08);
		chk(rv[10], 1'b0, "not_referenced");
		chk(cmd.pulse_enable, 1'b1, "pulse_enable");
		bus(0, 8'h50);
		chk(rv, 32'h0, "unmapped");
	endtask : t_power_up
	// controlled, path and retraction stops each settle in safe operating stop
	task automatic t_stops();
		for (int k = 2; k <= 4; k++) begin
			bus(1, 8'h04, 32'(1 << k));
			sts(3'(7 - k));
			repeat (520) @(posedge hclk);
			sts(3'h1);
			ack();
		end
	endtask : t_stops
	// ramp stop, then the other three braking stops at once; speed threshold ends the ramp before its timer
	task automatic t_ramp();
		bus(1, 8'h04, 32'h2);
		bus(1, 8'h04, 32'h1c);
		sts(3'h6);
		chk(cmd.fast_ramp, 1'b1, "fast_ramp");
		repeat (150) @(posedge hclk);
		sts(3'h7);
		chk(cmd.pulse_enable, 1'b0, "pulse_enable");
		ack();
		bus(1, 8'h04, 32'h1f);
		sts(3'h7);
		ack();
		sts(3'h0);
	endtask : t_ramp
	task automatic t_test_stop();
		stuck <= 1'b1;
		set(ctl | 32'h1);
		bus(0, 8'h08);
		chk(rv[13], 1'b1, "test_running");
		repeat (520) @(posedge hclk);
		sts(3'h7);
		stuck <= 1'b0;
		set(ctl & ~32'h1);
		bus(0, 8'h08);
		chk(rv[13], 1'b0, "test_running");
		ack();
	endtask : t_test_stop
	task automatic t_fault();
		set(32'h24);
		ext.xcmp_item <= 10'h2a;
		ext.xcmp_mismatch <= 1'b1;
		repeat (3) @(posedge hclk);
		sts(3'h2);
		bus(0, 8'h10);
		chk(rv, 32'h2a, "diag");
		repeat (520) @(posedge hclk);
		bus(0, 8'h08);
		ext.xcmp_mismatch <= 1'b0;
		chk(rv[3:2], 2'h3, "state");
		ack();
	endtask : t_fault
	// limit three active, path stop as response
	task automatic t_speed();
		bus(1, 8'h34, 32'h2);
		ext.speed <= 16'd60;
		set(32'h804);
		repeat (12) @(posedge hclk);
		sts(3'h4);
		bus(0, 8'h0c);
		chk(rv, 32'd300, "msg_value");
		ext.speed <= 16'd10;
		repeat (12) @(posedge hclk);
		ack();
	endtask : t_speed
	task automatic t_end();
		for (int i = 0; i < 4; i++) begin
			set(i < 2 ? 32'h104 : 32'h204);
			ext.pos <= i % 2 ? 32'd2000 : -32'sd2000;
			repeat (12) @(posedge hclk);
			bus(0, 8'h0c);
			chk(rv, 32'(i < 2 ? 10 : 20) + 32'(i % 2), "msg_value");
			ext.pos <= '0;
			repeat (12) @(posedge hclk);
			ack();
		end
	endtask : t_end
	task automatic conclude();
		if (n_fail == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	// hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = '0;
		stuck = 1'b0;
		ext = '{speed: 16'd100, saved_pos: 32'h5, default: '0};
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_cfg();
		t_power_up();
		t_stops();
		t_ramp();
		t_test_stop();
		t_fault();
		t_speed();
		t_end();
		conclude();
	end
endmodule : tb_safe_motion_stop_escalation
